//--- tpv_defines.svh
`ifndef TPV_DEFINES_SVH
`define TPV_DEFINES_SVH

// ==========================================================================
// Trap type codes
`define TPV_TT_INSTR_ACCESS 8'h01
`define TPV_TT_FP_EXC 8'h08
`define TPV_TT_TICC_BASE 8'h80
`define TPV_TT_IRQ_BASE 8'h10
`define TPV_SYNC_COUNT 10
`define TPV_FP_EXC_IDX 7

// ==========================================================================
// Vectoring layout and reset values
`define TPV_RESET_VECTOR 32'h0000_0000
`define TPV_TVB_RESET 20'h0_0000
`define TPV_TVB_LSB 12
`define TPV_TT_LSB 4
`define TPV_PC_STEP 32'h0000_0004

// ==========================================================================
// Pipeline timing
`define TPV_PIPE_DEPTH 4
`define TPV_FP_CORE_CYCLES 1

`endif

//--- tpv_pkg.sv
package tpv_pkg;

    // Trap class reported with every taken trap
    typedef enum logic [1:0] {
        TPV_CLS_NONE,
        TPV_CLS_SYNC,
        TPV_CLS_FPCP,
        TPV_CLS_ASYNC
    } tpv_class_e;

    typedef logic [7:0] tpv_tt_t;

endpackage

//--- tpv_prio_if.sv
`timescale 1ns/10ps
`default_nettype none

// Requests into the priority resolver and its verdict
interface tpv_prio_if;
    logic [9:0] sync_flags;
    logic ticc_fire;
    logic [6:0] ticc_low;
    logic fp_trap;
    logic async_ok;
    logic [3:0] irq_level;
    logic hit;
    tpv_pkg::tpv_class_e cls;
    tpv_pkg::tpv_tt_t tt;

    modport core (
        output sync_flags, ticc_fire, ticc_low, fp_trap, async_ok, irq_level,
        input hit, cls, tt
    );
    modport arb (
        input sync_flags, ticc_fire, ticc_low, fp_trap, async_ok, irq_level,
        output hit, cls, tt
    );
endinterface

`default_nettype wire

//--- tpv_trap_prio.sv
`timescale 1ns/10ps
`default_nettype none
`include "tpv_defines.svh"

// ==========================================================================
// Combinational trap priority resolver
module tpv_trap_prio (
    // Requests and verdict
    tpv_prio_if.arb p
);

    // Lowest-numbered set flag wins; index i carries type code i+1
    function automatic logic [3:0] tpv_first_set(input logic [9:0] f);
        logic [3:0] idx;
        idx = 4'hF;
        for (int i = `TPV_SYNC_COUNT - 1; i >= 0; i--)
        begin
            if (f[i])
            begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    logic [3:0] first_idx;

    // Ordered pick: hardware sync, then trap instr, then interrupts
    always_comb
    begin
        first_idx = tpv_first_set(p.sync_flags);
        p.hit = 1'b0;
        p.cls = tpv_pkg::TPV_CLS_NONE;
        p.tt = 8'h00;
        if (p.sync_flags != 10'h000)
        begin
            p.hit = 1'b1;
            p.tt = `TPV_TT_INSTR_ACCESS + {4'h0, first_idx};
            p.cls = (p.fp_trap && first_idx == 4'(`TPV_FP_EXC_IDX)) ?
                    tpv_pkg::TPV_CLS_FPCP : tpv_pkg::TPV_CLS_SYNC;
        end
        else if (p.ticc_fire)
        begin
            p.hit = 1'b1;
            p.cls = tpv_pkg::TPV_CLS_SYNC;
            p.tt = `TPV_TT_TICC_BASE | {1'b0, p.ticc_low};
        end
        else if (p.async_ok && p.irq_level != 4'h0)
        begin
            p.hit = 1'b1;
            p.cls = tpv_pkg::TPV_CLS_ASYNC;
            p.tt = `TPV_TT_IRQ_BASE | {4'h0, p.irq_level};
        end
    end

endmodule

`default_nettype wire

//--- tpv_trap_unit.sv
`timescale 1ns/10ps
`default_nettype none
`include "tpv_defines.svh"

// Summary of operation
// - Four stages F, D, E, W; result writes four cycles after entry.
// - Execute stage keeps results only in temporary registers.
// - Write stage updates destination only if that instruction raised no trap.
// - Floating-point operate holds the integer core for exactly one cycle.
// - Traps are classed synchronous, fp/coprocessor, or asynchronous interrupts.
// - Synchronous trap comes from the executing instruction, before it completes.
// - Fp/coprocessor trap raised before completion; later integer work may have run.
// - Asynchronous traps are taken only on instruction boundaries.
// - Sync and fp traps precede visible state change, except double-access ops.
// - Non-reset traps vector to trap table base plus type-code offset.
// - Reset is highest priority, has no code, and goes to address zero.
// - Both counters saved; pointing at faulting or next-to-execute instruction.
// - On fp trap the deferred queue keeps the offending instruction.
// - Sync priorities 2-11 carry codes 1-10 in the fixed order.
// - Trap instruction priority 12; interrupt levels 15..1 get codes 31..17.
// - Trap instruction code is 128 plus low seven bits of operand sum.
// - Traps taken in execute; younger annulled; handler runs fourth cycle after.
// - Four-bit interrupt level is synchronised and served in place of the execute-stage instruction.
module tpv_trap_unit (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Instruction issue into fetch
    input wire logic issue_i,
    // Execute-stage instruction information
    input wire logic [31:0] e_pc_i,
    input wire logic [31:0] e_npc_i,
    input wire logic [31:0] e_result_i,
    input wire logic [4:0] e_rd_i,
    input wire logic e_writes_rd_i,
    input wire logic e_fp_op_i,
    input wire logic e_second_access_i,
    input wire logic [9:0] e_sync_flags_i,
    input wire logic e_ticc_fire_i,
    input wire logic [31:0] e_ticc_rs1_i,
    input wire logic [31:0] e_ticc_op2_i,
    // Trap vector base write from the core
    input wire logic tvb_we_i,
    input wire logic [19:0] tvb_wdata_i,
    // Floating-point unit and interrupt pins
    input wire logic fp_trap_i,
    input wire logic irq_enable_i,
    input wire logic [3:0] interrupt_level_lines_i,
    // Pipeline state
    output logic e_valid_o,
    output logic fp_launch_o,
    // Register write-back
    output logic wb_en_o,
    output logic [4:0] wb_rd_o,
    output logic [31:0] wb_data_o,
    // Trap outcome
    output logic trap_o,
    output tpv_pkg::tpv_class_e trap_class_o,
    output tpv_pkg::tpv_tt_t trap_type_code_o,
    output logic redirect_o,
    output logic [31:0] redirect_addr_o,
    output logic [31:0] saved_pc_o,
    output logic [31:0] saved_npc_o,
    output logic fp_deferred_queue_hold_o
);

    // ======================================================================
    // Interrupt level synchroniser
    logic [3:0] irl_meta_r;
    logic [3:0] irl_sync_r;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            irl_meta_r <= 4'h0;
            irl_sync_r <= 4'h0;
        end
        else
        begin
            irl_meta_r <= interrupt_level_lines_i;
            irl_sync_r <= irl_meta_r;
        end
    end

    // ======================================================================
    // Priority resolver
    tpv_prio_if prio ();
    logic [31:0] ticc_sum;

    tpv_trap_prio u_prio (
        .p(prio.arb)
    );

    assign ticc_sum = e_ticc_rs1_i + e_ticc_op2_i;

    always_comb
    begin
        // sync only from a live execute instruction
        prio.sync_flags = e_valid_o ? e_sync_flags_i : 10'h000;
        if (e_valid_o && fp_trap_i)
        begin
            // deferred fp trap taken at next boundary
            prio.sync_flags[`TPV_FP_EXC_IDX] = 1'b1;
        end
        prio.fp_trap = fp_trap_i;
        prio.ticc_fire = e_valid_o && e_ticc_fire_i;
        prio.ticc_low = ticc_sum[6:0];
        // boundary only, never mid double access
        prio.async_ok = e_valid_o && !e_second_access_i && irq_enable_i;
        prio.irq_level = irl_sync_r;
    end

    // ======================================================================
    // Pipeline and write-back state
    logic f_vld_r;
    logic d_vld_r;
    logic e_vld_r;
    logic f_vld_nxt;
    logic d_vld_nxt;
    logic e_vld_nxt;
    logic wb_en_nxt;
    logic [4:0] wb_rd_nxt;
    logic [31:0] wb_data_nxt;
    logic fp_launch_nxt;
    logic [4:0] wb_rd_r;
    logic [31:0] wb_data_r;
    logic wb_en_r;
    logic fp_launch_r;

    // Next state of the four stages
    always_comb
    begin
        f_vld_nxt = issue_i;
        d_vld_nxt = f_vld_r;
        e_vld_nxt = d_vld_r;
        // annul younger work on a trap
        if (prio.hit)
        begin
            f_vld_nxt = 1'b0;
            d_vld_nxt = 1'b0;
            e_vld_nxt = 1'b0;
        end
        wb_en_nxt = e_vld_r && e_writes_rd_i && !prio.hit;
        // temporary result held until write stage
        wb_data_nxt = e_result_i;
        wb_rd_nxt = e_rd_i;
        // fp operate occupies one core cycle
        fp_launch_nxt = e_vld_r && e_fp_op_i && !prio.hit;
    end

    // Stage registers
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            f_vld_r <= 1'b0;
            d_vld_r <= 1'b0;
            e_vld_r <= 1'b0;
            wb_en_r <= 1'b0;
            wb_rd_r <= 5'h00;
            wb_data_r <= 32'h0000_0000;
            fp_launch_r <= 1'b0;
        end
        else
        begin
            f_vld_r <= f_vld_nxt;
            d_vld_r <= d_vld_nxt;
            e_vld_r <= e_vld_nxt;
            wb_en_r <= wb_en_nxt;
            wb_rd_r <= wb_rd_nxt;
            wb_data_r <= wb_data_nxt;
            fp_launch_r <= fp_launch_nxt;
        end
    end

    assign e_valid_o = e_vld_r;
    assign wb_en_o = wb_en_r;
    assign wb_rd_o = wb_rd_r;
    assign wb_data_o = wb_data_r;
    assign fp_launch_o = fp_launch_r;

    // ======================================================================
    // Trap vector base and trap outcome
    logic [19:0] tvb_r;
    logic [19:0] tvb_nxt;
    logic trap_r;
    logic trap_nxt;
    tpv_pkg::tpv_class_e cls_r;
    tpv_pkg::tpv_class_e cls_nxt;
    tpv_pkg::tpv_tt_t tt_r;
    tpv_pkg::tpv_tt_t tt_nxt;
    logic redir_r;
    logic redir_nxt;
    logic [31:0] redir_addr_r;
    logic [31:0] redir_addr_nxt;
    logic [31:0] spc_r;
    logic [31:0] spc_nxt;
    logic [31:0] snpc_r;
    logic [31:0] snpc_nxt;
    logic fq_hold_r;
    logic fq_hold_nxt;

    // Trap capture; class, code, address and counters hold until the next trap
    always_comb
    begin
        tvb_nxt = tvb_we_i ? tvb_wdata_i : tvb_r;
        trap_nxt = prio.hit;
        redir_nxt = prio.hit;
        cls_nxt = cls_r;
        tt_nxt = tt_r;
        redir_addr_nxt = redir_addr_r;
        spc_nxt = spc_r;
        snpc_nxt = snpc_r;
        fq_hold_nxt = 1'b0;
        if (prio.hit)
        begin
            cls_nxt = prio.cls;
            tt_nxt = prio.tt;
            redir_addr_nxt = {tvb_r, prio.tt, 4'h0};
            // execute instruction has not changed visible state yet
            spc_nxt = e_pc_i;
            snpc_nxt = e_npc_i;
            // fp unit keeps its queue entry
            fq_hold_nxt = (prio.cls == tpv_pkg::TPV_CLS_FPCP);
        end
    end

    // Trap outcome registers
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            tvb_r <= `TPV_TVB_RESET;
            trap_r <= 1'b0;
            cls_r <= tpv_pkg::TPV_CLS_NONE;
            tt_r <= 8'h00;
            // reset vectors to zero, no code
            redir_r <= 1'b1;
            redir_addr_r <= `TPV_RESET_VECTOR;
            spc_r <= 32'h0000_0000;
            snpc_r <= 32'h0000_0000;
            fq_hold_r <= 1'b0;
        end
        else
        begin
            tvb_r <= tvb_nxt;
            trap_r <= trap_nxt;
            cls_r <= cls_nxt;
            tt_r <= tt_nxt;
            // fetch redirect one cycle after detection
            redir_r <= redir_nxt;
            redir_addr_r <= redir_addr_nxt;
            spc_r <= spc_nxt;
            snpc_r <= snpc_nxt;
            fq_hold_r <= fq_hold_nxt;
        end
    end

    assign trap_o = trap_r;
    assign trap_class_o = cls_r;
    assign trap_type_code_o = tt_r;
    assign redirect_o = redir_r;
    assign redirect_addr_o = redir_addr_r;
    assign saved_pc_o = spc_r;
    assign saved_npc_o = snpc_r;
    assign fp_deferred_queue_hold_o = fq_hold_r;

endmodule

`default_nettype wire

//--- tpv_trap_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Port checker for the trap unit
module tpv_trap_sva (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Execute side
    input wire logic [31:0] e_pc_i,
    input wire logic [31:0] e_result_i,
    input wire logic e_writes_rd_i,
    input wire logic e_fp_op_i,
    input wire logic e_second_access_i,
    input wire logic e_valid_o,
    input wire logic fp_launch_o,
    // Results
    input wire logic wb_en_o,
    input wire logic [31:0] wb_data_o,
    input wire logic trap_o,
    input wire logic [1:0] trap_class_o,
    input wire tpv_pkg::tpv_tt_t trap_type_code_o,
    input wire logic redirect_o,
    input wire logic [31:0] redirect_addr_o,
    input wire logic [31:0] saved_pc_o,
    input wire logic fp_deferred_queue_hold_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // Reset vector, trap outcome against what execute held at detection, write-back and fp launch
    a_reset_to_zero: assert property ($fell(rst_i) |-> redirect_o && redirect_addr_o == 32'h0)
        else $error("reset vector wrong");
    a_trap_vectors: assert property (trap_o |-> redirect_o
        && redirect_addr_o[11:0] == {trap_type_code_o, 4'h0})
        else $error("handler address wrong");
    a_trap_blocks_wb: assert property (trap_o |-> !wb_en_o)
        else $error("write-back after trap");
    a_annul_younger: assert property (trap_o |-> !e_valid_o ##1 (!e_valid_o && !trap_o))
        else $error("younger work not annulled");
    a_sync_codes: assert property (trap_o && trap_class_o == tpv_pkg::TPV_CLS_SYNC
        |-> trap_type_code_o inside {[8'h01:8'h0A]} || trap_type_code_o[7])
        else $error("sync code out of range");
    a_async_codes: assert property (trap_o && trap_class_o == tpv_pkg::TPV_CLS_ASYNC
        |-> trap_type_code_o[7:4] == 4'h1 && trap_type_code_o[3:0] != 4'h0
        && $past(e_valid_o && !e_second_access_i))
        else $error("interrupt taken wrongly");
    a_fp_queue_hold: assert property (fp_deferred_queue_hold_o |-> trap_o
        && trap_class_o == tpv_pkg::TPV_CLS_FPCP && trap_type_code_o == 8'h08)
        else $error("queue hold without fp trap");
    a_saved_pc: assert property (trap_o |-> saved_pc_o == $past(e_pc_i) && $past(e_valid_o))
        else $error("saved counter wrong");
    a_wb_from_exec: assert property (wb_en_o |-> wb_data_o == $past(e_result_i)
        && $past(e_valid_o && e_writes_rd_i))
        else $error("write-back data wrong");
    a_fp_launch_once: assert property (fp_launch_o |-> $past(e_valid_o && e_fp_op_i) && !trap_o)
        else $error("fp launch without fp operate");
endmodule

bind tpv_trap_unit tpv_trap_sva u_tpv_trap_sva (.core_clk_i, .rst_i, .e_pc_i, .e_result_i,
    .e_writes_rd_i, .e_fp_op_i, .e_second_access_i, .e_valid_o, .fp_launch_o,
    .wb_en_o, .wb_data_o, .trap_o,
    .trap_class_o, .trap_type_code_o, .redirect_o, .redirect_addr_o, .saved_pc_o,
    .fp_deferred_queue_hold_o);
`default_nettype wire

//--- tpv_far_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Far side: interrupt sources and fp unit
module tpv_far_model (
    // Clock and commands
    input wire logic clk_i,
    input wire logic [3:0] lvl_cmd_i,
    input wire logic fp_cmd_i,
    // Lines into the trap unit
    output logic [3:0] irq_lvl_o,
    output logic fp_trap_o
);
    // fp trap as pending level
    // Moves off the sampling edge, like pins from another device
    always_ff @(negedge clk_i)
    begin
        irq_lvl_o <= lvl_cmd_i;
        fp_trap_o <= fp_cmd_i;
    end
endmodule
`default_nettype wire

//--- test_trap_priority_vectoring.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Bench for the trap unit
module test_trap_priority_vectoring;
    // Inputs
    logic core_clk_i, rst_i, issue_i, e_writes_rd_i, e_fp_op_i, e_second_access_i;
    logic e_ticc_fire_i, tvb_we_i, irq_enable_i, fp_cmd;
    logic [31:0] e_pc_i, e_npc_i, e_result_i, e_ticc_rs1_i, e_ticc_op2_i, pc;
    logic [4:0] e_rd_i;
    logic [9:0] e_sync_flags_i;
    logic [19:0] tvb_wdata_i;
    logic [3:0] lvl_cmd;
    wire fp_trap_i;
    wire [3:0] interrupt_level_lines_i;
    // Outputs
    logic e_valid_o, fp_launch_o, wb_en_o, trap_o, redirect_o, fp_deferred_queue_hold_o;
    logic [4:0] wb_rd_o;
    logic [31:0] wb_data_o, redirect_addr_o, saved_pc_o, saved_npc_o;
    tpv_pkg::tpv_class_e trap_class_o;
    tpv_pkg::tpv_tt_t trap_type_code_o;
    int err_total, n_compared;
    localparam logic [19:0] TVB = 20'hABCDE;

    tpv_trap_unit u_tpv_trap_unit (.core_clk_i, .rst_i, .issue_i, .e_pc_i, .e_npc_i,
        .e_result_i, .e_rd_i, .e_writes_rd_i, .e_fp_op_i, .e_second_access_i,
        .e_sync_flags_i, .e_ticc_fire_i, .e_ticc_rs1_i, .e_ticc_op2_i, .tvb_we_i,
        .tvb_wdata_i, .fp_trap_i, .irq_enable_i, .interrupt_level_lines_i, .e_valid_o,
        .fp_launch_o, .wb_en_o, .wb_rd_o, .wb_data_o, .trap_o, .trap_class_o,
        .trap_type_code_o, .redirect_o, .redirect_addr_o, .saved_pc_o, .saved_npc_o,
        .fp_deferred_queue_hold_o);
    tpv_far_model u_tpv_far_model (.clk_i(core_clk_i), .lvl_cmd_i(lvl_cmd),
        .fp_cmd_i(fp_cmd), .irq_lvl_o(interrupt_level_lines_i), .fp_trap_o(fp_trap_i));

    // 20 MHz clock
    initial
    begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    task chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1)
        begin
            err_total++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    task end_of_test;
        if (err_total == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Idle execute inputs between instructions
    task clr_e;
        {e_sync_flags_i, e_ticc_fire_i, e_fp_op_i, e_second_access_i, e_writes_rd_i} = '0;
        {e_pc_i, e_npc_i, e_result_i, e_rd_i} = '0;
    endtask

    // One instruction through the pipe, judged in its write cycle
    task run(input logic [9:0] fl, input logic tf, input logic fp, input logic [3:0] lv,
        input logic sa, input logic [7:0] xtt, input tpv_pkg::tpv_class_e xc);
        @(negedge core_clk_i);
        lvl_cmd = lv;
        fp_cmd = fp;
        repeat (3) @(negedge core_clk_i);
        issue_i = 1'b1;
        @(negedge core_clk_i);
        issue_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        chk(e_valid_o === 1'b1, "execute not valid");
        {e_sync_flags_i, e_ticc_fire_i, e_fp_op_i, e_second_access_i} = {fl, tf, fp, sa};
        {e_pc_i, e_npc_i, e_result_i, e_rd_i, e_writes_rd_i} = {pc, pc + 32'h4, ~pc, 5'h11, 1'b1};
        @(negedge core_clk_i);
        clr_e();
        lvl_cmd = 4'h0;
        fp_cmd = 1'b0;
        if (xc == tpv_pkg::TPV_CLS_NONE)
            chk(trap_o === 1'b0 && wb_en_o === 1'b1 && wb_data_o === ~pc && wb_rd_o === 5'h11,
                "write-back missing");
        else
            chk(trap_o === 1'b1 && wb_en_o === 1'b0 && trap_type_code_o === xtt
                && trap_class_o === xc && redirect_addr_o === {TVB, xtt, 4'h0}
                && saved_pc_o === pc && saved_npc_o === pc + 32'h4 && redirect_o === 1'b1
                && fp_deferred_queue_hold_o === (xc == tpv_pkg::TPV_CLS_FPCP),
                "trap outcome");
        pc = pc + 32'h10;
    endtask

    task t_reset;
        rst_i = 1'b1;
        repeat (16) @(negedge core_clk_i);
        rst_i = 1'b0;
        chk(redirect_o === 1'b1 && redirect_addr_o === 32'h0 && trap_o === 1'b0, "reset");
        @(negedge core_clk_i);
        chk(redirect_o === 1'b0 && e_valid_o === 1'b0, "reset redirect stuck");
        tvb_we_i = 1'b1;
        @(negedge core_clk_i);
        tvb_we_i = 1'b0;
    endtask

    // Two back to back issues reach execute on consecutive cycles
    task t_pipe;
        issue_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        issue_i = 1'b0;
        chk(e_valid_o === 1'b0, "execute early");
        @(negedge core_clk_i);
        chk(e_valid_o === 1'b1, "first not in execute");
        @(negedge core_clk_i);
        chk(e_valid_o === 1'b1, "second not in execute");
    endtask

    // Every lower cause pending too; the lowest index must win
    task t_sync_prio;
        for (int i = 0; i < 10; i++)
            run(10'h3FF << i, 1'b1, 1'b0, 4'h3, 1'b0, 8'(i + 1), tpv_pkg::TPV_CLS_SYNC);
    endtask

    task t_ticc;
        run(10'h000, 1'b1, 1'b0, 4'h0, 1'b0, 8'h95, tpv_pkg::TPV_CLS_SYNC);
        run(10'h200, 1'b1, 1'b0, 4'h0, 1'b0, 8'h0A, tpv_pkg::TPV_CLS_SYNC);
    endtask

    task t_fp;
        run(10'h000, 1'b0, 1'b1, 4'h0, 1'b0, 8'h08, tpv_pkg::TPV_CLS_FPCP);
        run(10'h001, 1'b0, 1'b1, 4'h0, 1'b0, 8'h01, tpv_pkg::TPV_CLS_SYNC);
    endtask

    // Fp operate with no trap launches for exactly one cycle
    task t_fp_launch;
        @(negedge core_clk_i);
        issue_i = 1'b1;
        @(negedge core_clk_i);
        issue_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        e_fp_op_i = 1'b1;
        @(negedge core_clk_i);
        e_fp_op_i = 1'b0;
        chk(fp_launch_o === 1'b1 && trap_o === 1'b0, "fp not launched");
        @(negedge core_clk_i);
        chk(fp_launch_o === 1'b0, "fp launch too long");
    endtask

    // Each level, then refusals at a second access, level zero and disabled
    task t_irq;
        for (int lv = 15; lv > 0; lv--)
            run(10'h0, 1'b0, 1'b0, 4'(lv), 1'b0, 8'(16 + lv), tpv_pkg::TPV_CLS_ASYNC);
        run(10'h0, 1'b0, 1'b0, 4'h5, 1'b1, 8'h00, tpv_pkg::TPV_CLS_NONE);
        run(10'h0, 1'b0, 1'b0, 4'h0, 1'b0, 8'h00, tpv_pkg::TPV_CLS_NONE);
        irq_enable_i = 1'b0;
        run(10'h0, 1'b0, 1'b0, 4'h9, 1'b0, 8'h00, tpv_pkg::TPV_CLS_NONE);
        irq_enable_i = 1'b1;
    endtask

    // Hang guard
    initial
    begin
        #1000000;
        err_total++;
        end_of_test();
    end

    initial
    begin
        {err_total, n_compared, pc} = '0;
        {rst_i, issue_i, tvb_we_i, irq_enable_i, fp_cmd, lvl_cmd} = {5'b10010, 4'h0};
        clr_e();
        tvb_wdata_i = TVB;
        e_ticc_rs1_i = 32'h0000_00F0;
        e_ticc_op2_i = 32'h0000_0025;
        t_reset();
        t_pipe();
        t_sync_prio();
        t_ticc();
        t_fp();
        t_fp_launch();
        t_irq();
        end_of_test();
    end
endmodule
`default_nettype wire
